// >>> phs_device.sv
`timescale 1ns/10ps
`default_nettype none
module phs_device #(
    parameter logic [15:0] FUSE_PLL_SETTING = 16'h0101,
    parameter logic [15:0] VOLTAGE_IDENTIFIER = 16'h00a5
) (
    input  wire logic                                 ref_clk_in,
    input  wire logic                                 sys_rst_in,
    phs_if.dev                                        link,
    input  wire logic [3:0]                           boot_config_pins_in,
    output logic      [15:0]                          pll_cfg_out,
    output logic      [phs_pkg::SCAN_REGS-1:0][15:0]  por_regs_out,
    output logic      [phs_pkg::RING_LEN-1:0]         cfg_ring_out,
    output logic      [1:0]                           por_phase_out,
    output logic                                      link_pll_up_out,
    output logic                                      core_hold_out,
    output logic                                      core_start_out
);
    import phs_pkg::*;

    typedef enum logic [3:0] {
        D_OFF, D_SCAN, D_FUSE, D_WAIT_RLS, D_REQ_CFG, D_PLL, D_CAL, D_FINISH, D_RUN
    } phs_dstate_t;

    phs_dstate_t       state_q;
    phs_dstate_t       state_d;
    logic [TMR_W-1:0]  tmr_q;
    logic              sclk_q;
    logic [TMR_W-1:0]  bit_cnt_q;
    logic [7:0]        hdr_q;
    logic [15:0]       rx_q;
    logic [15:0]       tx_q;
    logic              att_q;
    logic [1:0]        cause_q;
    logic              done_q;
    logic              ring_open_q;
    logic              ring_go_q;
    logic              ring_loaded_q;
    logic [TMR_W-1:0]  ring_idx_q;
    logic              cal_ack_q;
    logic              sclk_rise;
    logic              sclk_fall;
    logic [6:0]        hdr_addr;
    logic              status_rd;
    logic              done_wr;
    logic              ring_bit;
    logic              enter_p1;
    logic              enter_cfg;
    logic              enter_cal;

    function automatic logic [15:0] reg_read(input logic [6:0] addr, input logic [1:0] cause);
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            ADDR_STATUS_RD: begin
                w[CAUSE_HI_POS] = cause[1];
                w[CAUSE_LO_POS] = cause[0];
            end
            ADDR_VID_RD: w = VOLTAGE_IDENTIFIER;
            default: w = 16'h0000;
        endcase
        return w;
    endfunction : reg_read

    always_comb begin
        state_d = state_q;
        case (state_q)
            D_OFF:      if (link.external_reset_pin) state_d = D_SCAN;
            D_SCAN:     if (tmr_q == SCAN_LAST) state_d = D_FUSE;
            D_FUSE:     state_d = D_WAIT_RLS;
            D_WAIT_RLS: if (!link.external_reset_pin) state_d = D_REQ_CFG;
            D_REQ_CFG:  if (ring_loaded_q) state_d = D_PLL;
            D_PLL:      if (tmr_q == PLL_LOCK_CYC - 12'h001) state_d = D_CAL;
            D_CAL:      if (done_q) state_d = D_FINISH;
            D_FINISH:   state_d = D_RUN;
            D_RUN:      state_d = D_RUN;
            default:    state_d = D_OFF;
        endcase
        if (!link.supply_ok) begin
            state_d = D_OFF;
        end else if (link.external_reset_pin && state_q inside {D_REQ_CFG, D_PLL, D_CAL, D_FINISH, D_RUN}) begin
            state_d = D_SCAN;
        end
    end

    assign enter_p1  = (state_d == D_SCAN) && (state_q != D_SCAN);
    assign enter_cfg = (state_q == D_WAIT_RLS) && (state_d == D_REQ_CFG);
    assign enter_cal = (state_q == D_PLL) && (state_d == D_CAL);

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= D_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // one timer serves scan index, PLL lock wait and calibration time
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tmr_q <= '0;
        end else if (state_d != state_q) begin
            tmr_q <= '0;
        end else if (state_q inside {D_SCAN, D_PLL} || (state_q == D_CAL && link.cal_req && !cal_ack_q)) begin
            tmr_q <= tmr_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            por_regs_out <= {SCAN_REGS{SCAN_RST_VALUE}};
            pll_cfg_out  <= PLL_CFG_RST;
        end else if (state_q == D_SCAN) begin
            por_regs_out[tmr_q[SCAN_IDX_W-1:0]] <= SCAN_POR_VALUE;
        end else if (state_q == D_FUSE) begin
            pll_cfg_out <= (boot_config_pins_in == BOOT_NOMINAL) ? FUSE_PLL_SETTING : PLL_CFG_RST;
        end
    end

    // spi pins are taken as synchronous, edges are found against the last sample
    assign sclk_rise = !link.spi_cs_n && link.spi_sclk && !sclk_q;
    assign sclk_fall = !link.spi_cs_n && !link.spi_sclk && sclk_q;
    assign hdr_addr  = {hdr_q[5:0], link.spi_mosi};
    assign status_rd = sclk_rise && bit_cnt_q == HDR_LAST && !hdr_q[6] && hdr_addr == ADDR_STATUS_RD;
    assign done_wr   = sclk_rise && bit_cnt_q == WORD_LAST && hdr_q[WR_FLAG_POS]
                       && hdr_q[6:0] == ADDR_STATUS_WR && rx_q[DONE_POS-1] && state_q == D_CAL;
    assign ring_bit  = sclk_rise && bit_cnt_q >= HDR_END && hdr_q[WR_FLAG_POS]
                       && hdr_q[6:0] == ADDR_CFG_RING && ring_open_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_q    <= 1'b0;
            bit_cnt_q <= '0;
            hdr_q     <= 8'h00;
            rx_q      <= 16'h0000;
            tx_q      <= 16'h0000;
        end else begin
            sclk_q <= link.spi_sclk;
            if (link.spi_cs_n) begin
                bit_cnt_q <= '0;
            end else if (sclk_rise) begin
                if (bit_cnt_q < HDR_END) begin
                    hdr_q <= {hdr_q[6:0], link.spi_mosi};
                    if (bit_cnt_q == HDR_LAST && !hdr_q[6]) begin
                        tx_q <= reg_read(hdr_addr, cause_q);
                    end
                end else begin
                    rx_q <= {rx_q[14:0], link.spi_mosi};
                end
                if (bit_cnt_q < WORD_FRAME) begin
                    bit_cnt_q <= bit_cnt_q + 12'h001;
                end
            end else if (sclk_fall && bit_cnt_q > HDR_END && !hdr_q[WR_FLAG_POS]) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
        end
    end

    assign link.spi_miso = tx_q[15];

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            att_q   <= 1'b0;
            cause_q <= CAUSE_NONE;
            done_q  <= 1'b0;
        end else begin
            if (enter_cfg || enter_cal) begin
                att_q <= 1'b1;
            end else if (status_rd || enter_p1) begin
                att_q <= 1'b0;
            end
            if (enter_p1) begin
                cause_q <= CAUSE_NONE;
            end else if (enter_cfg) begin
                cause_q <= CAUSE_CFG;
            end else if (enter_cal) begin
                cause_q <= CAUSE_CAL;
            end
            if (done_wr) begin
                done_q <= 1'b1;
            end else if (state_q != D_CAL) begin
                done_q <= 1'b0;
            end
        end
    end

    assign link.attention = att_q;

    // zeros before the start bit and bits past the last ring bit fall through
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ring_open_q   <= 1'b0;
            ring_go_q     <= 1'b0;
            ring_loaded_q <= 1'b0;
            ring_idx_q    <= RING_LAST;
            cfg_ring_out  <= '0;
        end else if (enter_p1) begin
            ring_open_q   <= 1'b0;
            ring_go_q     <= 1'b0;
            ring_loaded_q <= 1'b0;
        end else begin
            if (enter_cfg) begin
                ring_open_q <= 1'b1;
            end
            if (link.spi_cs_n) begin
                ring_go_q <= 1'b0;
            end else if (ring_bit) begin
                if (!ring_go_q) begin
                    ring_go_q  <= link.spi_mosi;
                    ring_idx_q <= RING_LAST;
                end else begin
                    cfg_ring_out[ring_idx_q] <= link.spi_mosi;
                    if (ring_idx_q == '0) begin
                        ring_loaded_q <= 1'b1;
                        ring_open_q   <= 1'b0;
                    end else begin
                        ring_idx_q <= ring_idx_q - 12'h001;
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cal_ack_q <= 1'b0;
        end else if (state_q == D_CAL && link.cal_req) begin
            if (tmr_q == CAL_CYC - 12'h001) begin
                cal_ack_q <= 1'b1;
            end
        end else begin
            cal_ack_q <= 1'b0;
        end
    end

    assign link.cal_ack = cal_ack_q;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            por_phase_out   <= 2'h0;
            link_pll_up_out <= 1'b0;
            core_hold_out   <= 1'b1;
            core_start_out  <= 1'b0;
        end else begin
            case (state_d)
                D_OFF:                        por_phase_out <= 2'h0;
                D_SCAN, D_FUSE, D_WAIT_RLS:   por_phase_out <= 2'h1;
                default:                      por_phase_out <= 2'h2;
            endcase
            if (enter_p1 || state_d == D_OFF) begin
                link_pll_up_out <= 1'b0;
            end else if (enter_cal) begin
                link_pll_up_out <= 1'b1;
            end
            core_hold_out  <= !(state_d == D_RUN);
            core_start_out <= (state_q == D_FINISH);
        end
    end
endmodule : phs_device
`default_nettype wire

// >>> phs_pkg.sv
`default_nettype none
package phs_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TMR_W         = 12;

    // least times round up and never fall below one cycle
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : min_cycles

    localparam int             PG_WAIT_NS   = 2000;
    localparam int             RST_WAIT_NS  = 3000;
    localparam int             PLL_LOCK_NS  = 5000;
    localparam int             CAL_NS       = 2000;
    localparam int             SPI_HALF_NS  = 200;
    localparam logic [TMR_W-1:0] PG_WAIT_CYC  = TMR_W'(min_cycles(PG_WAIT_NS));
    localparam logic [TMR_W-1:0] RST_WAIT_CYC = TMR_W'(min_cycles(RST_WAIT_NS));
    localparam logic [TMR_W-1:0] PLL_LOCK_CYC = TMR_W'(min_cycles(PLL_LOCK_NS));
    localparam logic [TMR_W-1:0] CAL_CYC      = TMR_W'(min_cycles(CAL_NS));
    localparam logic [TMR_W-1:0] SPI_HALF_CYC = TMR_W'(min_cycles(SPI_HALF_NS));

    localparam int               SCAN_REGS      = 4;
    localparam int               SCAN_IDX_W     = 2;
    localparam logic [TMR_W-1:0] SCAN_LAST      = TMR_W'(SCAN_REGS - 1);
    localparam logic [15:0]      SCAN_POR_VALUE = 16'h0000;
    localparam logic [15:0]      SCAN_RST_VALUE = 16'hffff;

    localparam int               RING_LEN  = 2729;
    localparam logic [TMR_W-1:0] RING_LAST = TMR_W'(RING_LEN - 1);

    localparam int               HDR_BITS      = 8;
    localparam int               DATA_BITS     = 16;
    localparam logic [TMR_W-1:0] HDR_LAST      = TMR_W'(HDR_BITS - 1);
    localparam logic [TMR_W-1:0] HDR_END       = TMR_W'(HDR_BITS);
    localparam logic [TMR_W-1:0] WORD_LAST     = TMR_W'(HDR_BITS + DATA_BITS - 1);
    localparam logic [TMR_W-1:0] WORD_FRAME    = TMR_W'(HDR_BITS + DATA_BITS);
    localparam logic [TMR_W-1:0] RING_FRAME    = TMR_W'(HDR_BITS + 1 + RING_LEN);

    localparam int         WR_FLAG_POS   = 7;
    localparam logic [6:0] ADDR_STATUS_RD = 7'h00;
    localparam logic [6:0] ADDR_CFG_RING  = 7'h01;
    localparam logic [6:0] ADDR_VID_RD    = 7'h02;
    localparam logic [6:0] ADDR_STATUS_WR = 7'h03;

    localparam int         CAUSE_HI_POS = 5;
    localparam int         CAUSE_LO_POS = 4;
    localparam int         DONE_POS     = 7;
    localparam logic [1:0] CAUSE_NONE   = 2'h0;
    localparam logic [1:0] CAUSE_CFG    = 2'h2;
    localparam logic [1:0] CAUSE_CAL    = 2'h1;

    localparam logic [3:0]  BOOT_NOMINAL = 4'h0;
    localparam logic [15:0] PLL_CFG_RST  = 16'h0000;
endpackage : phs_pkg
`default_nettype wire

// >>> phs_if.sv
`timescale 1ns/10ps
`default_nettype none
interface phs_if;
    logic supply_ok;
    logic external_reset_pin;
    logic attention;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_mosi;
    logic spi_miso;
    logic cal_req;
    logic cal_ack;

    modport dev (input supply_ok, external_reset_pin, spi_sclk, spi_cs_n, spi_mosi, cal_req,
                 output attention, spi_miso, cal_ack);
    modport ctl (output supply_ok, external_reset_pin, spi_sclk, spi_cs_n, spi_mosi, cal_req,
                 input attention, spi_miso, cal_ack);
endinterface : phs_if
`default_nettype wire

// >>> phs_controller.sv
`timescale 1ns/10ps
`default_nettype none
module phs_controller (
    input  wire logic                         ref_clk_in,
    input  wire logic                         sys_rst_in,
    phs_if.ctl                                link,
    input  wire logic                         supplies_ok_in,
    input  wire logic                         vreg_settled_in,
    input  wire logic                         io_cal_done_in,
    input  wire logic                         warm_reset_req_in,
    input  wire logic [phs_pkg::RING_LEN-1:0] ring_image_in,
    output logic                              clk_gen_en_out,
    output logic      [15:0]                  voltage_identifier_out,
    output logic                              vid_valid_out,
    output logic                              seq_done_out,
    output logic                              seq_error_out
);
    import phs_pkg::*;

    typedef enum logic [3:0] {
        C_PWR, C_PG_WAIT, C_RST_WAIT, C_WAIT_ATT1, C_RD_ST1, C_RD_VID, C_VREG, C_WR_RING,
        C_WAIT_ATT2, C_RD_ST2, C_CAL, C_WR_DONE, C_DONE, C_ERR
    } phs_cstate_t;

    phs_cstate_t       state_q;
    phs_cstate_t       state_d;
    logic [TMR_W-1:0]  tmr_q;
    logic              go;
    logic [7:0]        hdr_d;
    logic [TMR_W-1:0]  len_d;
    logic [7:0]        hdr_q;
    logic [TMR_W-1:0]  len_q;
    logic [15:0]       wdata_q;
    logic              busy_q;
    logic              done_q;
    logic [TMR_W-1:0]  pos_q;
    logic [TMR_W-1:0]  div_q;
    logic [15:0]       rd_q;
    logic [1:0]        cause;

    // ring frames carry a start bit then ring bit 2728 first, down to bit 0
    function automatic logic frame_bit(input logic [TMR_W-1:0] pos, input logic [7:0] hdr,
                                       input logic [15:0] wdata, input logic [RING_LEN-1:0] ring);
        int p;
        p = int'(pos);
        if (p < HDR_BITS) return hdr[HDR_BITS-1-p];
        if (hdr[6:0] != ADDR_CFG_RING) return wdata[HDR_BITS+DATA_BITS-1-p];
        if (p == HDR_BITS) return 1'b1;
        return ring[RING_LEN+HDR_BITS-p];
    endfunction : frame_bit

    assign cause = {rd_q[CAUSE_HI_POS], rd_q[CAUSE_LO_POS]};

    always_comb begin
        hdr_d = 8'h00;
        len_d = WORD_FRAME;
        case (state_q)
            C_RD_ST1, C_RD_ST2: hdr_d = {1'b0, ADDR_STATUS_RD};
            C_RD_VID:           hdr_d = {1'b0, ADDR_VID_RD};
            C_WR_RING: begin
                hdr_d = {1'b1, ADDR_CFG_RING};
                len_d = RING_FRAME;
            end
            C_WR_DONE:          hdr_d = {1'b1, ADDR_STATUS_WR};
            default:            hdr_d = 8'h00;
        endcase
    end

    assign go = state_q inside {C_RD_ST1, C_RD_VID, C_WR_RING, C_RD_ST2, C_WR_DONE} && !busy_q && !done_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            C_PWR:       if (supplies_ok_in) state_d = C_PG_WAIT;
            C_PG_WAIT:   if (tmr_q == PG_WAIT_CYC - 12'h001) state_d = C_RST_WAIT;
            C_RST_WAIT:  if (tmr_q == RST_WAIT_CYC - 12'h001) state_d = C_WAIT_ATT1;
            C_WAIT_ATT1: if (link.attention) state_d = C_RD_ST1;
            C_RD_ST1:    if (done_q) state_d = (cause == CAUSE_CFG) ? C_RD_VID : C_ERR;
            C_RD_VID:    if (done_q) state_d = C_VREG;
            C_VREG:      if (vreg_settled_in) state_d = C_WR_RING;
            C_WR_RING:   if (done_q) state_d = C_WAIT_ATT2;
            C_WAIT_ATT2: if (link.attention) state_d = C_RD_ST2;
            C_RD_ST2:    if (done_q) state_d = (cause == CAUSE_CAL) ? C_CAL : C_ERR;
            C_CAL:       if (link.cal_ack && io_cal_done_in) state_d = C_WR_DONE;
            C_WR_DONE:   if (done_q) state_d = C_DONE;
            C_DONE:      if (warm_reset_req_in) state_d = C_RST_WAIT;
            C_ERR:       state_d = C_ERR;
            default:     state_d = C_PWR;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= C_PWR;
            tmr_q   <= '0;
        end else begin
            state_q <= state_d;
            tmr_q   <= (state_d != state_q) ? '0 : tmr_q + 12'h001;
        end
    end

    // mode 0 master: mosi moves after the falling edge, miso is taken on the rising edge
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_q        <= 1'b0;
            done_q        <= 1'b0;
            link.spi_cs_n <= 1'b1;
            link.spi_sclk <= 1'b0;
            link.spi_mosi <= 1'b0;
            hdr_q         <= 8'h00;
            len_q         <= '0;
            wdata_q       <= 16'h0000;
            pos_q         <= '0;
            div_q         <= '0;
            rd_q          <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            if (go) begin
                busy_q         <= 1'b1;
                link.spi_cs_n  <= 1'b0;
                hdr_q          <= hdr_d;
                len_q          <= len_d;
                wdata_q        <= 16'h0000;
                wdata_q[DONE_POS] <= 1'b1;
                pos_q          <= '0;
                div_q          <= '0;
                link.spi_mosi  <= frame_bit('0, hdr_d, 16'h0080, ring_image_in);
            end else if (busy_q) begin
                if (div_q == SPI_HALF_CYC - 12'h001) begin
                    div_q <= '0;
                    if (!link.spi_sclk) begin
                        link.spi_sclk <= 1'b1;
                        if (pos_q >= HDR_END) begin
                            rd_q <= {rd_q[14:0], link.spi_miso};
                        end
                    end else begin
                        link.spi_sclk <= 1'b0;
                        if (pos_q == len_q - 12'h001) begin
                            busy_q        <= 1'b0;
                            done_q        <= 1'b1;
                            link.spi_cs_n <= 1'b1;
                        end else begin
                            pos_q         <= pos_q + 12'h001;
                            link.spi_mosi <= frame_bit(pos_q + 12'h001, hdr_q, wdata_q, ring_image_in);
                        end
                    end
                end else begin
                    div_q <= div_q + 12'h001;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            link.supply_ok          <= 1'b0;
            link.external_reset_pin <= 1'b1;
            link.cal_req            <= 1'b0;
            clk_gen_en_out          <= 1'b0;
            voltage_identifier_out  <= 16'h0000;
            vid_valid_out           <= 1'b0;
            seq_done_out            <= 1'b0;
            seq_error_out           <= 1'b0;
        end else begin
            clk_gen_en_out          <= 1'b1;
            link.supply_ok          <= !(state_d inside {C_PWR, C_PG_WAIT});
            link.external_reset_pin <= state_d inside {C_PWR, C_PG_WAIT, C_RST_WAIT};
            link.cal_req            <= (state_d == C_CAL);
            if (state_q == C_RD_VID && done_q) begin
                voltage_identifier_out <= rd_q;
                vid_valid_out          <= 1'b1;
            end
            seq_done_out  <= (state_d == C_DONE);
            seq_error_out <= (state_d == C_ERR);
        end
    end
endmodule : phs_controller
`default_nettype wire

// >>> phs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module phs_sva (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic supply_ok,
    input wire logic external_reset_pin,
    input wire logic attention,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic cal_req,
    input wire logic cal_ack
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // sixteen cycles is a floor on the held reset, not the full wait
    sequence s_rst_held;
        external_reset_pin [*8] ##1 external_reset_pin [*8];
    endsequence
    AST_RST_HOLD: assert property ($rose(supply_ok) |-> s_rst_held)
        else $error("reset pin released too soon after supply ok");
    AST_ATTN_PHASE: assert property ($rose(attention) |-> supply_ok && !external_reset_pin)
        else $error("service request raised while still in reset");
    AST_ATTN_RELEASE: assert property ($rose(attention) |-> ##[1:400] !attention)
        else $error("service request never released");
    AST_CAL_ACK_REQ: assert property ($rose(cal_ack) |-> cal_req && $past(cal_req, 19))
        else $error("calibration ack without long enough request");
    AST_CAL_ACK_DROP: assert property ($fell(cal_req) |-> ##[0:2] !cal_ack)
        else $error("calibration ack held after request dropped");
    AST_SCLK_IDLE: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_sclk)
        else $error("serial clock high between frames");
    AST_SCLK_HI: assert property ($rose(spi_sclk) |=> spi_sclk)
        else $error("serial clock high phase too short");
    AST_SCLK_LO: assert property ($fell(spi_sclk) && !spi_cs_n |=> !spi_sclk)
        else $error("serial clock low phase too short");
endmodule : phs_sva
`default_nettype wire

// >>> por_handshake_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module por_handshake_sequencer_bench;
    import phs_pkg::*;
    logic ref_clk_in = 0, sys_rst_in = 1, supplies_ok_in = 0, vreg_settled_in = 0, io_cal_done_in = 0;
    logic warm_reset_req_in = 0, clk_gen_en_out, vid_valid_out, seq_done_out, seq_error_out;
    logic link_pll_up_out, core_hold_out, core_start_out;
    logic [3:0] boot_config_pins_in = 4'h0;
    logic [RING_LEN-1:0] ring_image_in = '0, cfg_ring_out;
    logic [15:0] voltage_identifier_out, pll_cfg_out;
    logic [SCAN_REGS-1:0][15:0] por_regs_out;
    logic [1:0] por_phase_out;
    int n_errors = 0, n_checks = 0, cycles = 0, starts = 0;
    phs_if i_phs_if ();
    phs_device #(.FUSE_PLL_SETTING(16'h1234), .VOLTAGE_IDENTIFIER(16'h005c)) i_phs_device (.ref_clk_in,
        .sys_rst_in, .link(i_phs_if), .boot_config_pins_in, .pll_cfg_out, .por_regs_out, .cfg_ring_out,
        .por_phase_out, .link_pll_up_out, .core_hold_out, .core_start_out);
    phs_controller i_phs_controller (.ref_clk_in, .sys_rst_in, .link(i_phs_if), .supplies_ok_in,
        .vreg_settled_in, .io_cal_done_in, .warm_reset_req_in, .ring_image_in, .clk_gen_en_out,
        .voltage_identifier_out, .vid_valid_out, .seq_done_out, .seq_error_out);
    phs_sva i_phs_sva (.ref_clk_in, .sys_rst_in, .supply_ok(i_phs_if.supply_ok),
        .external_reset_pin(i_phs_if.external_reset_pin), .attention(i_phs_if.attention),
        .spi_sclk(i_phs_if.spi_sclk), .spi_cs_n(i_phs_if.spi_cs_n), .cal_req(i_phs_if.cal_req),
        .cal_ack(i_phs_if.cal_ack));
    initial forever #50 ref_clk_in = ~ref_clk_in;
    // regulator and io partner settle one cycle after they are asked
    always @(posedge ref_clk_in) begin
        vreg_settled_in <= vid_valid_out;
        io_cal_done_in  <= link_pll_up_out;
        cycles <= cycles + 1;
        if (core_start_out === 1'b1) starts <= starts + 1;
        if (cycles == 40000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic check(input logic [RING_LEN-1:0] seen, input logic [RING_LEN-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic run_seq(input logic [3:0] pins, input logic [RING_LEN-1:0] img, input logic warm);
        @(posedge ref_clk_in);
        boot_config_pins_in <= pins;
        ring_image_in       <= img;
        supplies_ok_in      <= 1'b1;
        warm_reset_req_in   <= warm;
        starts = 0;
        do @(posedge ref_clk_in); while (seq_done_out === 1'b1 && warm);
        warm_reset_req_in <= 1'b0;
        do @(posedge ref_clk_in); while (por_phase_out !== 2'h1);
        #10 check(core_hold_out, 1'b1);
        do @(posedge ref_clk_in); while (por_phase_out !== 2'h2);
        #10 check(por_regs_out, '0);
        check(pll_cfg_out, (pins == 4'h0) ? 16'h1234 : 16'h0000);
        check(i_phs_if.external_reset_pin, 1'b0);
        do @(posedge ref_clk_in); while (link_pll_up_out !== 1'b1);
        #10 check(cfg_ring_out, img);
        check(voltage_identifier_out, 16'h005c);
        check(vid_valid_out, 1'b1);
        do @(posedge ref_clk_in); while (seq_done_out !== 1'b1);
        repeat (4) @(posedge ref_clk_in);
        #10 check(starts, 1);
        check(core_hold_out, 1'b0);
        check(seq_error_out, 1'b0);
    endtask : run_seq
    initial begin
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        #10 check(clk_gen_en_out, 1'b1);
        check(por_regs_out, {SCAN_REGS{SCAN_RST_VALUE}});
        check(core_hold_out, 1'b1);
        run_seq(4'h0, {3'b110, {(RING_LEN-4){1'b0}}, 1'b1}, 1'b0);
        // warm restart must load a fresh ring and rescan like a cold start
        run_seq(4'h3, {3'b011, {(RING_LEN-4){1'b1}}, 1'b0}, 1'b1);
        close_out();
    end
endmodule : por_handshake_sequencer_bench
`default_nettype wire
